// ===== core/flash_reset_cfg.svh
`ifndef FLASH_RESET_CFG_SVH
`define FLASH_RESET_CFG_SVH
// ==========================================
// clock
`define CLK_PERIOD_NS 100
// ==========================================
// opcodes
`define READ_PARAM_TABLE_CMD 8'h5A
`define RESET_ARM_CMD 8'h66
`define RESET_EXEC_CMD 8'h99
`define PARAM_ADDR_BYTES 3
`define PARAM_DUMMY_BYTES 1
// ==========================================
// times in their printed units
`define RESET_PULSE_MIN_US 10
`define RESET_TO_SELECT_GAP_US 10
`define POWERUP_RECOVERY_US 35
`define DECODE_RECOVERY_US 40
`define READ_RECOVERY_US 40
`define PROGRAM_RECOVERY_US 310
`define SECTOR_RECOVERY_MS 12
`define BLOCK_RECOVERY_MS 25
`define CHIP_RECOVERY_MS 1000
`define STATUS_RECOVERY_MS 40
// power_up_delay has no printed figure: plain default
`define POWER_UP_DELAY_US 100
// ==========================================
// cycle counts, least times rounded up
`define US_TO_CYC(t) ((((t) * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MS_TO_CYC(t) ((((t) * 1000000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_MIN_CYC `US_TO_CYC(`RESET_PULSE_MIN_US)
`define GAP_CYC `US_TO_CYC(`RESET_TO_SELECT_GAP_US)
`define POWERUP_RECOVERY_CYC `US_TO_CYC(`POWERUP_RECOVERY_US)
`define DECODE_RECOVERY_CYC `US_TO_CYC(`DECODE_RECOVERY_US)
`define READ_RECOVERY_CYC `US_TO_CYC(`READ_RECOVERY_US)
`define PROGRAM_RECOVERY_CYC `US_TO_CYC(`PROGRAM_RECOVERY_US)
`define POWER_UP_DELAY_CYC `US_TO_CYC(`POWER_UP_DELAY_US)
// ==========================================
// reset values
`define ADDR4_RESET 1'b0
`endif

// ===== core/flash_reset_pkg.sv
package flash_reset_pkg;
	typedef enum logic [4:0] {
		ST_OPCODE = 5'h01,
		ST_ADDR = 5'h02,
		ST_DUMMY = 5'h04,
		ST_DATA = 5'h08,
		ST_IGNORE = 5'h10
	} bus_state_t;
	typedef enum logic [2:0] {
		OP_IDLE = 3'h0,
		OP_READ = 3'h1,
		OP_PROGRAM = 3'h2,
		OP_SECTOR_ERASE = 3'h3,
		OP_BLOCK_ERASE = 3'h4,
		OP_CHIP_ERASE = 3'h5,
		OP_STATUS_WRITE = 3'h6
	} op_kind_t;
endpackage

// ===== core/flash_reset_param_read.sv
`timescale 1ns/10ps
`include "flash_reset_cfg.svh"
// Contract
// - 5Ah, three address, one dummy, then data
// - select high ends read, output released
// - reset low ten microseconds is full reset
// - after reset standby, volatile bits cleared, 3-byte
// - reset aborts running program or erase
// - output high impedance during reset
// - power-up in standby, write latch cleared
// - below threshold: logic reset, commands ignored
// - 99h acts only directly after 66h
// - other command cancels armed reset
module flash_reset_param_read #(
	parameter int unsigned SECTOR_RECOVERY_CYC = `MS_TO_CYC(`SECTOR_RECOVERY_MS),
	parameter int unsigned BLOCK_RECOVERY_CYC = `MS_TO_CYC(`BLOCK_RECOVERY_MS),
	parameter int unsigned CHIP_RECOVERY_CYC = `MS_TO_CYC(`CHIP_RECOVERY_MS),
	parameter int unsigned STATUS_RECOVERY_CYC = `MS_TO_CYC(`STATUS_RECOVERY_MS)
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	input wire logic hw_reset_n_in,
	input wire logic por_ok_in,
	input wire logic [2:0] op_kind_in,
	input wire logic [7:0] table_data_in,
	input wire logic write_latch_set_in,
	input wire logic write_latch_clr_in,
	input wire logic write_busy_set_in,
	input wire logic write_busy_clr_in,
	input wire logic lock_set_in,
	input wire logic addr4_set_in,
	output logic so_out,
	output logic so_oe_out,
	output logic [23:0] table_addr_out,
	output logic write_latch_bit_out,
	output logic write_busy_bit_out,
	output logic lock_bit_out,
	output logic addr4_mode_out,
	output logic standby_out,
	output logic abort_op_out,
	output logic ready_out
);
	// ==========================================
	// pin synchronisers
	// order: sclk, cs_n, si, hw_reset_n, por_ok
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic sclk_prev;
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			sync1 <= 5'h1A;
			sync2 <= 5'h1A;
			sclk_prev <= 1'b0;
		end else if (clk_en_in) begin
			sync1 <= {por_ok_in, hw_reset_n_in, si_in, cs_n_in, sclk_in};
			sync2 <= sync1;
			sclk_prev <= sync2[0];
		end
	end
	logic sclk_rise;
	logic sclk_fall;
	logic cs_n_s;
	logic si_s;
	logic rst_pin_s;
	logic core_rst;
	assign sclk_rise = sync2[0] & ~sclk_prev;
	assign sclk_fall = ~sync2[0] & sclk_prev;
	assign cs_n_s = sync2[1];
	assign si_s = sync2[2];
	assign rst_pin_s = sync2[3];
	// supply below threshold holds everything else in reset
	assign core_rst = !reset_n_in || !sync2[4];
	// ==========================================
	// hardware reset pulse and recovery timer
	logic [23:0] low_cnt;
	logic full_pulse;
	logic [23:0] rec_cnt;
	logic [23:0] next_rec;
	logic soft_reset;
	logic bus_busy;
	logic reset_event;
	logic rst_rise;
	logic rst_pin_prev;
	assign rst_rise = rst_pin_s & ~rst_pin_prev;
	// a short glitch does not count as a reset
	assign reset_event = (rst_rise && full_pulse) || soft_reset;
	always_comb begin
		next_rec = 24'(`DECODE_RECOVERY_CYC);
		case (op_kind_in)
			flash_reset_pkg::OP_READ: next_rec = 24'(`READ_RECOVERY_CYC);
			flash_reset_pkg::OP_PROGRAM: next_rec = 24'(`PROGRAM_RECOVERY_CYC);
			flash_reset_pkg::OP_SECTOR_ERASE: next_rec = 24'(SECTOR_RECOVERY_CYC);
			flash_reset_pkg::OP_BLOCK_ERASE: next_rec = 24'(BLOCK_RECOVERY_CYC);
			flash_reset_pkg::OP_CHIP_ERASE: next_rec = 24'(CHIP_RECOVERY_CYC);
			flash_reset_pkg::OP_STATUS_WRITE: next_rec = 24'(STATUS_RECOVERY_CYC);
			default: next_rec = 24'(`DECODE_RECOVERY_CYC);
		endcase
		// the reset-to-select gap is the floor of every wait
		if (next_rec < 24'(`GAP_CYC)) begin
			next_rec = 24'(`GAP_CYC);
		end
	end
	always_ff @(posedge clk_in) begin
		if (core_rst) begin
			low_cnt <= 24'h000000;
			full_pulse <= 1'b0;
			rst_pin_prev <= 1'b1;
			// power-up wait: the longer of power-up delay and recovery
			rec_cnt <= 24'((`POWER_UP_DELAY_CYC > `POWERUP_RECOVERY_CYC) ?
				`POWER_UP_DELAY_CYC : `POWERUP_RECOVERY_CYC);
		end else if (clk_en_in) begin
			rst_pin_prev <= rst_pin_s;
			if (!rst_pin_s) begin
				if (low_cnt != 24'(`RESET_PULSE_MIN_CYC)) begin
					low_cnt <= low_cnt + 24'h000001;
				end else begin
					full_pulse <= 1'b1;
				end
			end else begin
				low_cnt <= 24'h000000;
				full_pulse <= 1'b0;
			end
			if (reset_event) begin
				rec_cnt <= next_rec;
			end else if (rec_cnt != 24'h000000) begin
				rec_cnt <= rec_cnt - 24'h000001;
			end
		end
	end
	// ignore the bus while the pin is low or recovery runs
	assign bus_busy = !rst_pin_s || rec_cnt != 24'h000000;
	always_ff @(posedge clk_in) begin
		if (core_rst) begin
			abort_op_out <= 1'b0;
			ready_out <= 1'b0;
			standby_out <= 1'b1;
		end else if (clk_en_in) begin
			// abort only when something is really running
			abort_op_out <= reset_event && op_kind_in != 3'(flash_reset_pkg::OP_IDLE);
			ready_out <= !bus_busy && !reset_event;
			standby_out <= 1'b1;
		end
	end
	// ==========================================
	// volatile bits
	always_ff @(posedge clk_in) begin
		if (core_rst || reset_event) begin
			write_latch_bit_out <= 1'b0;
			write_busy_bit_out <= 1'b0;
			lock_bit_out <= 1'b0;
			addr4_mode_out <= `ADDR4_RESET;
		end else if (clk_en_in) begin
			if (write_latch_set_in) begin
				write_latch_bit_out <= 1'b1;
			end else if (write_latch_clr_in) begin
				write_latch_bit_out <= 1'b0;
			end
			if (write_busy_set_in) begin
				write_busy_bit_out <= 1'b1;
			end else if (write_busy_clr_in) begin
				write_busy_bit_out <= 1'b0;
			end
			if (lock_set_in) begin
				lock_bit_out <= 1'b1;
			end
			if (addr4_set_in) begin
				addr4_mode_out <= 1'b1;
			end
		end
	end
	// ==========================================
	// serial command decode
	flash_reset_pkg::bus_state_t state;
	logic [7:0] in_shift;
	logic [7:0] next_byte;
	logic [2:0] bit_cnt;
	logic [1:0] byte_cnt;
	logic armed;
	logic [7:0] out_shift;
	assign next_byte = {in_shift[6:0], si_s};
	always_ff @(posedge clk_in) begin
		if (core_rst) begin
			state <= flash_reset_pkg::ST_OPCODE;
			in_shift <= 8'h00;
			bit_cnt <= 3'h0;
			byte_cnt <= 2'h0;
			armed <= 1'b0;
			soft_reset <= 1'b0;
			table_addr_out <= 24'h000000;
		end else if (clk_en_in) begin
			soft_reset <= 1'b0;
			if (cs_n_s || bus_busy) begin
				// deselect ends any frame, including a table read
				state <= flash_reset_pkg::ST_OPCODE;
				bit_cnt <= 3'h0;
				byte_cnt <= 2'h0;
				if (bus_busy) begin
					armed <= 1'b0;
				end
			end else if (sclk_rise) begin
				in_shift <= next_byte;
				bit_cnt <= bit_cnt + 3'h1;
				case (state)
					flash_reset_pkg::ST_OPCODE: begin
						if (bit_cnt == 3'h7) begin
							armed <= (next_byte == `RESET_ARM_CMD);
							if (next_byte == `RESET_EXEC_CMD && armed) begin
								soft_reset <= 1'b1;
								state <= flash_reset_pkg::ST_IGNORE;
							end else if (next_byte == `READ_PARAM_TABLE_CMD) begin
								state <= flash_reset_pkg::ST_ADDR;
							end else begin
								state <= flash_reset_pkg::ST_IGNORE;
							end
						end
					end
					flash_reset_pkg::ST_ADDR: begin
						if (bit_cnt == 3'h7) begin
							table_addr_out <= {table_addr_out[15:0], next_byte};
							byte_cnt <= byte_cnt + 2'h1;
							if (byte_cnt == 2'(`PARAM_ADDR_BYTES - 1)) begin
								byte_cnt <= 2'h0;
								state <= flash_reset_pkg::ST_DUMMY;
							end
						end
					end
					flash_reset_pkg::ST_DUMMY: begin
						if (bit_cnt == 3'h7) begin
							byte_cnt <= byte_cnt + 2'h1;
							if (byte_cnt == 2'(`PARAM_DUMMY_BYTES - 1)) begin
								state <= flash_reset_pkg::ST_DATA;
							end
						end
					end
					flash_reset_pkg::ST_DATA: begin
						if (bit_cnt == 3'h7) begin
							table_addr_out <= table_addr_out + 24'h000001;
						end
					end
					flash_reset_pkg::ST_IGNORE: begin
						bit_cnt <= 3'h0;
					end
					default: begin
						state <= flash_reset_pkg::ST_OPCODE;
					end
				endcase
			end
		end
	end
	// ==========================================
	// serial output, changed on the falling clock edge
	always_ff @(posedge clk_in) begin
		if (core_rst) begin
			out_shift <= 8'h00;
			so_out <= 1'b0;
			so_oe_out <= 1'b0;
		end else if (clk_en_in) begin
			if (!rst_pin_s || cs_n_s || bus_busy || state != flash_reset_pkg::ST_DATA) begin
				so_oe_out <= 1'b0;
				so_out <= 1'b0;
			end else if (sclk_fall) begin
				so_oe_out <= 1'b1;
				if (bit_cnt == 3'h0) begin
					so_out <= table_data_in[7];
					out_shift <= {table_data_in[6:0], 1'b0};
				end else begin
					so_out <= out_shift[7];
					out_shift <= {out_shift[6:0], 1'b0};
				end
			end
		end
	end
endmodule

// ===== tb/flash_reset_monitor.sv
`timescale 1ns/10ps
// ==========================================
// port checks
module flash_reset_monitor (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic cs_n_in,
	input wire logic hw_reset_n_in,
	input wire logic por_ok_in,
	input wire logic [2:0] op_kind_in,
	input wire logic so_oe_out,
	input wire logic write_latch_bit_out,
	input wire logic write_busy_bit_out,
	input wire logic lock_bit_out,
	input wire logic addr4_mode_out,
	input wire logic standby_out,
	input wire logic abort_op_out,
	input wire logic ready_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// five samples: two sync stages plus output register, with one cycle to spare
	a_standby_always: assert property (standby_out) else $error("standby low");
	a_oe_off_reset: assert property (!hw_reset_n_in [*5] |-> !so_oe_out) else $error("so driven in reset");
	a_ready_reset: assert property (!hw_reset_n_in [*5] |-> !ready_out) else $error("ready in reset");
	a_por_holds: assert property (!por_ok_in [*5] |-> !ready_out && !so_oe_out) else $error("por ignored");
	a_oe_cs_high: assert property (cs_n_in [*5] |-> !so_oe_out) else $error("so driven deselected");
	a_oe_needs_ready: assert property ($rose(so_oe_out) |-> ready_out && !cs_n_in) else $error("so early");
	a_abort_pulse: assert property (abort_op_out |=> !abort_op_out) else $error("abort too long");
	a_abort_cause: assert property (abort_op_out |-> $past(op_kind_in) != 3'h0) else $error("abort no op");
	a_bits_cleared: assert property (abort_op_out |=> !write_latch_bit_out && !write_busy_bit_out
		&& !lock_bit_out && !addr4_mode_out) else $error("bits kept");
	c_read: cover property ($rose(so_oe_out));
	c_abort: cover property (abort_op_out);
	c_ready: cover property ($rose(ready_out));
endmodule
bind flash_reset_param_read flash_reset_monitor flash_reset_monitor_i (.*);

// ===== tb/flash_host_model.sv
`timescale 1ns/10ps
// ==========================================
// mode 0 host, clock parked low between frames
module flash_host_model (
	input wire logic clk_in,
	input wire logic so_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic si_out
);
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end
	task automatic half();
		repeat (4) @(negedge clk_in);
	endtask
	task automatic sel();
		cs_n_out = 1'b0;
		half();
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk_out = 1'b0;
			si_out = tx[i];
			half();
			sclk_out = 1'b1;
			rx[i] = so_in;
			half();
		end
	endtask
	task automatic desel();
		sclk_out = 1'b0;
		half();
		cs_n_out = 1'b1;
		si_out = ~si_out; // released line must not keep a stale level
		half();
	endtask
	task automatic cmd(input logic [7:0] op);
		logic [7:0] r;
		sel();
		xfer(op, r);
		desel();
	endtask
endmodule

// ===== tb/tb_flash_reset_param_read.sv
`timescale 1ns/10ps
// ==========================================
// bench
module tb_flash_reset_param_read;
	logic clk, reset_n, hw_n, por_ok, wl_set, wb_set, lk_set, a4_set;
	logic sclk, cs_n, si, so, so_oe, wl, wb, lk, a4, abort_op, ready;
	logic clk_en, wl_clr, wb_clr, standby, so_line;
	int aborts = 0;
	logic [2:0] op_kind;
	logic [23:0] taddr;
	logic [7:0] tdata, rx;
	int fail_count = 0;
	int total_checks = 0;
	assign tdata = taddr[7:0] ^ 8'h3C;
	// released output shows the inverse so a stale bit is never taken
	assign so_line = so_oe ? so : ~so;
	// one-cycle abort pulses, counted mid-cycle
	always @(negedge clk) begin
		if (abort_op === 1'b1) begin
			aborts++;
		end
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	flash_host_model flash_host_model_i (.clk_in(clk), .so_in(so_line), .sclk_out(sclk), .cs_n_out(cs_n),
		.si_out(si));
	// small erase counts keep the run short
	flash_reset_param_read #(.SECTOR_RECOVERY_CYC(200), .BLOCK_RECOVERY_CYC(200), .CHIP_RECOVERY_CYC(200),
		.STATUS_RECOVERY_CYC(200)) flash_reset_param_read_i (.clk_in(clk), .reset_n_in(reset_n),
		.clk_en_in(clk_en), .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si), .hw_reset_n_in(hw_n), .por_ok_in(por_ok),
		.op_kind_in(op_kind), .table_data_in(tdata), .write_latch_set_in(wl_set), .write_latch_clr_in(wl_clr),
		.write_busy_set_in(wb_set), .write_busy_clr_in(wb_clr), .lock_set_in(lk_set), .addr4_set_in(a4_set),
		.so_out(so), .so_oe_out(so_oe), .table_addr_out(taddr), .write_latch_bit_out(wl),
		.write_busy_bit_out(wb), .lock_bit_out(lk), .addr4_mode_out(a4), .standby_out(standby),
		.abort_op_out(abort_op), .ready_out(ready));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic conclude();
		if (fail_count == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wait_ready(input int lim);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		check("ready", 8'h01, {7'h00, ready});
	endtask
	task automatic set_bits();
		{wl_set, wb_set, lk_set, a4_set} = 4'hF;
		@(negedge clk);
		{wl_set, wb_set, lk_set, a4_set} = 4'h0;
		@(negedge clk);
	endtask
	task automatic pin_reset(input int low);
		hw_n = 1'b0;
		repeat (low) @(negedge clk);
		check("so_oe", 8'h00, {7'h00, so_oe});
		hw_n = 1'b1;
		repeat (5) @(negedge clk);
	endtask
	initial begin
		{reset_n, hw_n, por_ok, op_kind} = 6'h18;
		{clk_en, wl_clr, wb_clr} = 3'h4;
		{wl_set, wb_set, lk_set, a4_set} = 4'h0;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		repeat (900) @(negedge clk);
		check("early", 8'h00, {wl, wb, lk, ready});
		check("standby", 8'h01, {7'h00, standby});
		wait_ready(200);
		flash_host_model_i.sel();
		flash_host_model_i.xfer(8'h5A, rx);
		flash_host_model_i.xfer(8'h00, rx);
		flash_host_model_i.xfer(8'h01, rx);
		flash_host_model_i.xfer(8'hF0, rx);
		flash_host_model_i.xfer(8'h00, rx);
		flash_host_model_i.xfer(8'h00, rx);
		check("byte0", 8'hF0 ^ 8'h3C, rx);
		flash_host_model_i.xfer(8'h00, rx);
		check("byte1", 8'hF1 ^ 8'h3C, rx);
		check("addr_mid", 8'h01, taddr[15:8]);
		flash_host_model_i.desel();
		check("so_oe", 8'h00, {7'h00, so_oe});
		set_bits();
		flash_host_model_i.cmd(8'h66);
		flash_host_model_i.cmd(8'h00);
		flash_host_model_i.cmd(8'h99);
		check("kept", 8'h0F, {wl, wb, lk, a4});
		flash_host_model_i.cmd(8'h66);
		flash_host_model_i.cmd(8'h99);
		check("soft", 8'h00, {wl, wb, lk, a4, ready});
		check("abort", 8'h00, 8'(aborts));
		wait_ready(500);
		// enable low: set pulses must not land, ready stays as it was
		clk_en = 1'b0;
		set_bits();
		check("frozen", 8'h01, {wl, wb, lk, a4, ready});
		clk_en = 1'b1;
		set_bits();
		pin_reset(50);
		check("short", 8'h0F, {wl, wb, lk, a4});
		// set beats clear on the write latch
		{wl_set, wl_clr, wb_clr} = 3'h7;
		@(negedge clk);
		{wl_set, wl_clr, wb_clr} = 3'h0;
		@(negedge clk);
		check("clear", 8'h0B, {wl, wb, lk, a4});
		wait_ready(500);
		op_kind = 3'h2;
		pin_reset(110);
		op_kind = 3'h0;
		check("hard", 8'h00, {wl, wb, lk, a4});
		check("abort", 8'h01, 8'(aborts));
		check("standby", 8'h01, {7'h00, standby});
		repeat (2900) @(negedge clk);
		check("busy", 8'h00, {7'h00, ready});
		wait_ready(400);
		for (int k = 3; k < 7; k++) begin
			op_kind = 3'(k);
			pin_reset(110);
			op_kind = 3'h0;
			// 200-cycle wait: still busy past the 100-cycle floor
			repeat (150) @(negedge clk);
			check("rec", 8'h00, {7'h00, ready});
			wait_ready(100);
			check("abort", 8'(k - 1), 8'(aborts));
		end
		por_ok = 1'b0;
		repeat (3) @(negedge clk);
		set_bits();
		check("por", 8'h00, {wl, wb, lk, a4, ready});
		por_ok = 1'b1;
		wait_ready(1200);
		conclude();
	end
	initial begin
		#3000000;
		fail_count++;
		conclude();
	end
endmodule
